/* File: design/srd_pkg.sv */
package srd_pkg;
  // operation codes; shift group codes equal the operation selector
  localparam logic [3:0] OP_ROTATE_LEFT = 4'h0;
  localparam logic [3:0] OP_ROTATE_RIGHT = 4'h1;
  localparam logic [3:0] OP_ROTATE_LEFT_VIA_CARRY = 4'h2;
  localparam logic [3:0] OP_ROTATE_RIGHT_VIA_CARRY = 4'h3;
  localparam logic [3:0] OP_LOGICAL_SHIFT_LEFT = 4'h4;
  localparam logic [3:0] OP_LOGICAL_SHIFT_RIGHT = 4'h5;
  localparam logic [3:0] OP_ARITH_SHIFT_RIGHT = 4'h7;
  localparam logic [3:0] OP_DOUBLE_LEFT_SHIFT = 4'h8;
  localparam logic [3:0] OP_DOUBLE_RIGHT_SHIFT = 4'h9;
  localparam logic [3:0] OP_AND_REG = 4'hA;
  // selector value with no defined operation
  localparam logic [2:0] SEL_UNDEF = 3'h6;
  // opcode patterns
  localparam logic [6:0] PAT_SHIFT_ONE = 7'h68;
  localparam logic [6:0] PAT_SHIFT_CNT = 7'h69;
  localparam logic [6:0] PAT_SHIFT_IMM = 7'h60;
  localparam logic [5:0] PAT_AND_RR = 6'h08;
  localparam logic [7:0] PAT_ESCAPE = 8'h0F;
  localparam logic [7:0] PAT_DBL_LEFT_IMM = 8'hA4;
  localparam logic [7:0] PAT_DBL_LEFT_CNT = 8'hA5;
  localparam logic [7:0] PAT_DBL_RIGHT_IMM = 8'hAC;
  localparam logic [7:0] PAT_DBL_RIGHT_CNT = 8'hAD;
  localparam logic [1:0] MOD_REG = 2'h3;
  // count source
  localparam logic [1:0] CNT_NONE = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;
  localparam logic [1:0] CNT_LOW_REG = 2'h2;
  localparam logic [1:0] CNT_IMM = 2'h3;
  // clock budget classes and counts
  localparam logic [1:0] CLS_SHIFT = 2'h0;
  localparam logic [1:0] CLS_CARRY = 2'h1;
  localparam logic [1:0] CLS_AND = 2'h2;
  localparam logic [3:0] CYC_SHIFT_REG = 4'h3;
  localparam logic [3:0] CYC_SHIFT_MEM = 4'h7;
  localparam logic [3:0] CYC_CARRY_REG = 4'h9;
  localparam logic [3:0] CYC_CARRY_MEM = 4'hA;
  localparam logic [3:0] CYC_AND = 4'h2;
  // reset values
  localparam logic [3:0] RST_CYCLES = 4'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

/* File: design/srd_cycle_table.sv */
`timescale 1ns/10ps
`default_nettype none
// holds the clock budget of the last decoded instruction
module srd_cycle_table (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic load_i,
  input wire logic [1:0] cls_i,
  input wire logic mem_i,
  output logic [3:0] cycles_o
);
  logic [3:0] cycles_nxt;

  assign cycles_nxt = (cls_i == srd_pkg::CLS_AND) ? srd_pkg::CYC_AND :
                      (cls_i == srd_pkg::CLS_CARRY) ?
                        (mem_i ? srd_pkg::CYC_CARRY_MEM : srd_pkg::CYC_CARRY_REG) :
                        (mem_i ? srd_pkg::CYC_SHIFT_MEM : srd_pkg::CYC_SHIFT_REG);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cycles_o <= srd_pkg::RST_CYCLES;
    end else if (load_i) begin
      cycles_o <= cycles_nxt;
    end
  end
endmodule // srd_cycle_table
`default_nettype wire

/* File: design/srd_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - 1101000w plus ModR/M decodes as shift/rotate by one; 3 or 7 clocks.
// - 1101001w plus ModR/M shifts by count_low_register; 3 or 7 clocks.
// - 1100000w, ModR/M, 8-bit immediate shifts by immediate; 3 or 7 clocks.
// - rotates through carry take 9 clocks on register, 10 on memory.
// - selector maps 000..101 and 111 to the seven shift and rotate operations.
// - 0F A4, ModR/M, immediate decodes as double left shift; 3 or 7 clocks.
// - 0F A5, ModR/M decodes as double left shift by count register.
// - 0F AC, ModR/M, immediate decodes as double right shift; 3 or 7 clocks.
// - 0F AD, ModR/M decodes as double right shift by count register.
// - 001000dw with register ModR/M decodes as AND of registers; 2 clocks.
module srd_decoder #(
  parameter bit UNDEF_FAULT = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic byte_vld_i,
  input wire logic [7:0] byte_i,
  output logic dec_vld_o,
  output logic undef_o,
  output logic [3:0] op_o,
  output logic size_o,
  output logic dir_o,
  output logic [1:0] cnt_src_o,
  output logic [7:0] imm_cnt_o,
  output logic [1:0] mod_o,
  output logic [2:0] reg_o,
  output logic [2:0] rm_o,
  output logic mem_o,
  output logic [3:0] cycles_o
);
  typedef enum logic [3:0] {
    ST_OP = 4'h1,
    ST_ESC = 4'h2,
    ST_MODRM = 4'h4,
    ST_IMM = 4'h8
  } srd_state_t;

  typedef enum logic [2:0] {
    FAM_SHIFT = 3'h1,
    FAM_DOUBLE = 3'h2,
    FAM_AND = 3'h4
  } srd_fam_t;

  srd_state_t st_r, st_nxt;
  srd_fam_t fam_r, fam_nxt;
  logic [1:0] src_r, src_nxt;
  logic size_r, size_nxt;
  logic dir_r, dir_nxt;
  logic dbl_right_r, dbl_right_nxt;
  logic [7:0] modrm_r;

  // first byte decode
  wire is_one = byte_i[7:1] == srd_pkg::PAT_SHIFT_ONE;
  wire is_cnt = byte_i[7:1] == srd_pkg::PAT_SHIFT_CNT;
  wire is_imm = byte_i[7:1] == srd_pkg::PAT_SHIFT_IMM;
  wire is_and = byte_i[7:2] == srd_pkg::PAT_AND_RR;
  wire is_esc = byte_i == srd_pkg::PAT_ESCAPE;
  wire is_shift = is_one | is_cnt | is_imm;
  // second byte decode after the escape
  wire is_dl_imm = byte_i == srd_pkg::PAT_DBL_LEFT_IMM;
  wire is_dl_cnt = byte_i == srd_pkg::PAT_DBL_LEFT_CNT;
  wire is_dr_imm = byte_i == srd_pkg::PAT_DBL_RIGHT_IMM;
  wire is_dr_cnt = byte_i == srd_pkg::PAT_DBL_RIGHT_CNT;
  wire is_dbl = is_dl_imm | is_dl_cnt | is_dr_imm | is_dr_cnt;

  // ModR/M currently being finished: live byte or the one held before the immediate
  wire [7:0] mrm = (st_r == ST_IMM) ? modrm_r : byte_i;
  wire [2:0] sel = mrm[5:3];
  wire mrm_mem = mrm[7:6] != srd_pkg::MOD_REG;
  wire sel_undef = (fam_r == FAM_SHIFT) && (sel == srd_pkg::SEL_UNDEF);
  // memory forms of AND are outside this decoder
  wire and_mem = (fam_r == FAM_AND) && mrm_mem;

  wire at_modrm = (st_r == ST_MODRM) && byte_vld_i;
  wire at_imm = (st_r == ST_IMM) && byte_vld_i;
  wire need_imm = src_r == srd_pkg::CNT_IMM;
  wire finish = (at_modrm && !need_imm) || at_imm;
  wire reject_mrm = at_modrm && (and_mem || (sel_undef && UNDEF_FAULT));
  wire bad_first = (st_r == ST_OP) && byte_vld_i && !(is_shift || is_and || is_esc);
  wire bad_esc = (st_r == ST_ESC) && byte_vld_i && !is_dbl;
  wire reject = bad_first || bad_esc || reject_mrm;
  wire done = finish && !reject_mrm;

  // the undefined selector reaches here only when aliasing is chosen
  wire [3:0] shift_op = sel_undef ? srd_pkg::OP_LOGICAL_SHIFT_LEFT : {1'b0, sel};
  wire [3:0] op_nxt = (fam_r == FAM_AND) ? srd_pkg::OP_AND_REG :
                      (fam_r == FAM_DOUBLE) ?
                        (dbl_right_r ? srd_pkg::OP_DOUBLE_RIGHT_SHIFT :
                                       srd_pkg::OP_DOUBLE_LEFT_SHIFT) :
                        shift_op;
  wire is_carry = (op_nxt == srd_pkg::OP_ROTATE_LEFT_VIA_CARRY) ||
                  (op_nxt == srd_pkg::OP_ROTATE_RIGHT_VIA_CARRY);
  wire [1:0] cls = (fam_r == FAM_AND) ? srd_pkg::CLS_AND :
                   is_carry ? srd_pkg::CLS_CARRY : srd_pkg::CLS_SHIFT;

  // first byte, or the byte after the escape, sets family, count source, size and direction
  wire [1:0] src_first = is_one ? srd_pkg::CNT_ONE :
                         is_cnt ? srd_pkg::CNT_LOW_REG :
                         is_imm ? srd_pkg::CNT_IMM : srd_pkg::CNT_NONE;
  wire [1:0] src_esc = (is_dl_imm || is_dr_imm) ? srd_pkg::CNT_IMM :
                       srd_pkg::CNT_LOW_REG;

  always_comb begin
    st_nxt = st_r;
    fam_nxt = fam_r;
    src_nxt = src_r;
    size_nxt = size_r;
    dir_nxt = dir_r;
    dbl_right_nxt = dbl_right_r;
    unique case (st_r)
      ST_OP: begin
        if (byte_vld_i && (is_shift || is_and)) begin
          st_nxt = ST_MODRM;
          fam_nxt = is_and ? FAM_AND : FAM_SHIFT;
          src_nxt = src_first;
          size_nxt = byte_i[0];
          dir_nxt = is_and & byte_i[1];
        end else if (byte_vld_i && is_esc) begin
          st_nxt = ST_ESC;
        end
      end
      ST_ESC: begin
        if (byte_vld_i) begin
          // double shifts always work on full-width operands
          st_nxt = is_dbl ? ST_MODRM : ST_OP;
          fam_nxt = FAM_DOUBLE;
          src_nxt = src_esc;
          size_nxt = 1'b1;
          dir_nxt = 1'b0;
          dbl_right_nxt = is_dr_imm | is_dr_cnt;
        end
      end
      ST_MODRM: begin
        if (byte_vld_i) begin
          st_nxt = (need_imm && !reject_mrm) ? ST_IMM : ST_OP;
        end
      end
      ST_IMM: begin
        if (byte_vld_i) begin
          st_nxt = ST_OP;
        end
      end
      default: begin
        st_nxt = ST_OP;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= ST_OP;
      fam_r <= FAM_SHIFT;
      src_r <= srd_pkg::CNT_NONE;
      size_r <= 1'b0;
      dir_r <= 1'b0;
      dbl_right_r <= 1'b0;
      modrm_r <= srd_pkg::RST_BYTE;
    end else begin
      st_r <= st_nxt;
      fam_r <= fam_nxt;
      src_r <= src_nxt;
      size_r <= size_nxt;
      dir_r <= dir_nxt;
      dbl_right_r <= dbl_right_nxt;
      if (at_modrm) begin
        modrm_r <= byte_i;
      end
    end
  end

  // result fields hold until the next completed decode
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dec_vld_o <= 1'b0;
      undef_o <= 1'b0;
      op_o <= srd_pkg::OP_ROTATE_LEFT;
      size_o <= 1'b0;
      dir_o <= 1'b0;
      cnt_src_o <= srd_pkg::CNT_NONE;
      imm_cnt_o <= srd_pkg::RST_BYTE;
      mod_o <= 2'h0;
      reg_o <= 3'h0;
      rm_o <= 3'h0;
      mem_o <= 1'b0;
    end else begin
      dec_vld_o <= done;
      undef_o <= reject;
      if (done) begin
        op_o <= op_nxt;
        size_o <= size_r;
        dir_o <= dir_r;
        cnt_src_o <= src_r;
        imm_cnt_o <= at_imm ? byte_i : srd_pkg::RST_BYTE;
        mod_o <= mrm[7:6];
        reg_o <= mrm[5:3];
        rm_o <= mrm[2:0];
        mem_o <= mrm_mem;
      end
    end
  end

  srd_cycle_table u_cycles (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .load_i(done),
    .cls_i(cls),
    .mem_i(mrm_mem),
    .cycles_o(cycles_o)
  );

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  wire op_vld = st_r == ST_OP && byte_vld_i;
  wire mrm_ok = byte_vld_i && byte_i[5:3] != srd_pkg::SEL_UNDEF;

  by_one_a: assert property (op_vld && is_one ##1 mrm_ok |=>
    dec_vld_o && cnt_src_o == srd_pkg::CNT_ONE && size_o == $past(byte_i[0], 2))
    else $error("by-one shift not decoded");
  by_count_a: assert property (op_vld && is_cnt ##1 mrm_ok |=>
    dec_vld_o && cnt_src_o == srd_pkg::CNT_LOW_REG)
    else $error("count register shift not decoded");
  by_imm_a: assert property (op_vld && is_imm ##1 mrm_ok ##1 byte_vld_i |=>
    dec_vld_o && cnt_src_o == srd_pkg::CNT_IMM && imm_cnt_o == $past(byte_i))
    else $error("immediate shift not decoded");
  carry_cycles_a: assert property (dec_vld_o &&
    (op_o == srd_pkg::OP_ROTATE_LEFT_VIA_CARRY || op_o == srd_pkg::OP_ROTATE_RIGHT_VIA_CARRY)
    |-> cycles_o == (mem_o ? srd_pkg::CYC_CARRY_MEM : srd_pkg::CYC_CARRY_REG))
    else $error("carry rotate clock budget wrong");
  shift_cycles_a: assert property (dec_vld_o && op_o != srd_pkg::OP_AND_REG &&
    op_o != srd_pkg::OP_ROTATE_LEFT_VIA_CARRY && op_o != srd_pkg::OP_ROTATE_RIGHT_VIA_CARRY
    |-> cycles_o == (mem_o ? srd_pkg::CYC_SHIFT_MEM : srd_pkg::CYC_SHIFT_REG))
    else $error("shift clock budget wrong");
  sel_map_a: assert property (at_modrm && fam_r == FAM_SHIFT && !need_imm &&
    byte_i[5:3] != srd_pkg::SEL_UNDEF |=> op_o == {1'b0, $past(byte_i[5:3])})
    else $error("selector mapped wrong");
  dbl_left_imm_a: assert property (st_r == ST_ESC && byte_vld_i && is_dl_imm
    ##1 byte_vld_i ##1 byte_vld_i |=> dec_vld_o && op_o == srd_pkg::OP_DOUBLE_LEFT_SHIFT &&
    cnt_src_o == srd_pkg::CNT_IMM)
    else $error("double left immediate not decoded");
  dbl_left_cnt_a: assert property (st_r == ST_ESC && byte_vld_i && is_dl_cnt
    ##1 byte_vld_i |=> dec_vld_o && op_o == srd_pkg::OP_DOUBLE_LEFT_SHIFT &&
    cnt_src_o == srd_pkg::CNT_LOW_REG)
    else $error("double left by count not decoded");
  dbl_right_imm_a: assert property (st_r == ST_ESC && byte_vld_i && is_dr_imm
    ##1 byte_vld_i ##1 byte_vld_i |=> dec_vld_o && op_o == srd_pkg::OP_DOUBLE_RIGHT_SHIFT &&
    cnt_src_o == srd_pkg::CNT_IMM)
    else $error("double right immediate not decoded");
  dbl_right_cnt_a: assert property (st_r == ST_ESC && byte_vld_i && is_dr_cnt
    ##1 byte_vld_i |=> dec_vld_o && op_o == srd_pkg::OP_DOUBLE_RIGHT_SHIFT)
    else $error("double right by count not decoded");
  and_reg_a: assert property (op_vld && is_and ##1 byte_vld_i &&
    byte_i[7:6] == srd_pkg::MOD_REG |=> dec_vld_o && op_o == srd_pkg::OP_AND_REG &&
    cycles_o == srd_pkg::CYC_AND && dir_o == $past(byte_i[1], 2))
    else $error("register AND not decoded");
  undef_sel_a: assert property (at_modrm && sel_undef |=>
    (UNDEF_FAULT ? (undef_o && !dec_vld_o && st_r == ST_OP) :
    (need_imm ? st_r == ST_IMM : dec_vld_o && op_o == srd_pkg::OP_LOGICAL_SHIFT_LEFT)))
    else $error("undefined selector mishandled");

  carry_mem_c: cover property (dec_vld_o && cycles_o == srd_pkg::CYC_CARRY_MEM);
  dbl_imm_c: cover property (dec_vld_o && op_o == srd_pkg::OP_DOUBLE_RIGHT_SHIFT &&
    cnt_src_o == srd_pkg::CNT_IMM);
  and_c: cover property (dec_vld_o && op_o == srd_pkg::OP_AND_REG);
  undef_c: cover property (undef_o);
endmodule // srd_decoder
`default_nettype wire

/* File: verif/srd_byte_feeder.sv */
`timescale 1ns/10ps
`default_nettype none
// prefetch side: hands over one instruction, whole, in order
module srd_byte_feeder (
  input wire logic ref_clk_i,
  output logic byte_vld_o,
  output logic [7:0] byte_o
);
  initial begin
    byte_vld_o = 1'b0;
    byte_o = 8'h00;
  end
  // released lines show the inverse of the last byte, never a stale copy
  task automatic send(input logic [7:0] q [$], input bit stall);
    foreach (q[i]) begin
      @(posedge ref_clk_i);
      byte_vld_o <= 1'b1;
      byte_o <= q[i];
      if (stall && i < q.size() - 1) begin
        @(posedge ref_clk_i);
        byte_vld_o <= 1'b0;
        byte_o <= ~q[i];
      end
    end
    @(posedge ref_clk_i);
    byte_vld_o <= 1'b0;
    byte_o <= ~byte_o;
  endtask
endmodule // srd_byte_feeder
`default_nettype wire

/* File: verif/shift_rotate_and_decoder_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module shift_rotate_and_decoder_bench;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic byte_vld;
  logic [7:0] byte_b;
  logic dec_vld;
  logic undef;
  logic [3:0] op;
  logic size;
  logic dir;
  logic [1:0] cnt;
  logic [7:0] imm;
  logic [1:0] mod;
  logic [2:0] rg;
  logic [2:0] rm;
  logic mem;
  logic [3:0] cyc;
  // second decoder with selector 110 aliased instead of faulted
  logic a_vld;
  logic a_undef;
  logic [3:0] a_op;
  logic [7:0] a_imm;
  logic [3:0] a_cyc;
  logic [7:0] qb [$];
  int n_mismatch = 0;
  int n_checks = 0;
  int clk_count = 0;

  initial forever #25 ref_clk_i = ~ref_clk_i;

  srd_byte_feeder feeder (.ref_clk_i(ref_clk_i), .byte_vld_o(byte_vld), .byte_o(byte_b));
  srd_decoder dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .byte_vld_i(byte_vld),
    .byte_i(byte_b), .dec_vld_o(dec_vld), .undef_o(undef), .op_o(op), .size_o(size),
    .dir_o(dir), .cnt_src_o(cnt), .imm_cnt_o(imm), .mod_o(mod), .reg_o(rg), .rm_o(rm),
    .mem_o(mem), .cycles_o(cyc));
  srd_decoder #(.UNDEF_FAULT(1'b0)) dut_alias (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .byte_vld_i(byte_vld), .byte_i(byte_b), .dec_vld_o(a_vld), .undef_o(a_undef),
    .op_o(a_op), .size_o(), .dir_o(), .cnt_src_o(), .imm_cnt_o(a_imm), .mod_o(), .reg_o(),
    .rm_o(), .mem_o(), .cycles_o(a_cyc));

  task report_and_stop;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // far longer than the whole sequence needs
  always @(posedge ref_clk_i) begin
    clk_count++;
    if (clk_count > 2000) begin
      n_mismatch++;
      report_and_stop;
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task run(input bit stall);
    feeder.send(qb, stall);
    #1;
  endtask

  // all fields at the pulse, then the pulse must be gone one cycle later
  task expect_dec(input logic [3:0] e_op, input logic e_size, input logic e_dir,
      input logic [1:0] e_cnt, input logic [7:0] e_imm, input logic [7:0] e_modrm,
      input logic [3:0] e_cyc);
    chk({dec_vld, undef}, 2'h2);
    chk(op, e_op);
    chk(size, e_size);
    chk(dir, e_dir);
    chk(cnt, e_cnt);
    chk(imm, e_imm);
    chk({mod, rg, rm}, e_modrm);
    chk(mem, e_modrm[7:6] != srd_pkg::MOD_REG);
    chk(cyc, e_cyc);
    @(posedge ref_clk_i);
    #1;
    chk(dec_vld, 1'b0);
  endtask

  function automatic logic [3:0] budget(input logic [2:0] sel, input logic m);
    if (sel == 3'h2 || sel == 3'h3) return m ? srd_pkg::CYC_CARRY_MEM : srd_pkg::CYC_CARRY_REG;
    return m ? srd_pkg::CYC_SHIFT_MEM : srd_pkg::CYC_SHIFT_REG;
  endfunction

  task t_by_one;
    logic [7:0] mr;
    for (int s = 0; s < 8; s++) begin
      for (int m = 0; m < 2; m++) begin
        if (s != 6) begin
          mr = {(m == 1) ? 2'h1 : 2'h3, s[2:0], 3'h2};
          qb = '{8'hD1, mr};
          run(1'b0);
          expect_dec(s[3:0], 1'b1, 1'b0, srd_pkg::CNT_ONE, 8'h00, mr, budget(s[2:0], m[0]));
        end
      end
    end
  endtask

  task t_by_count;
    qb = '{8'hD2, 8'h2B};
    run(1'b1);
    expect_dec(srd_pkg::OP_LOGICAL_SHIFT_RIGHT, 1'b0, 1'b0, srd_pkg::CNT_LOW_REG, 8'h00, 8'h2B, 4'h7);
    qb = '{8'hD3, 8'hD8};
    run(1'b0);
    expect_dec(srd_pkg::OP_ROTATE_RIGHT_VIA_CARRY, 1'b1, 1'b0, srd_pkg::CNT_LOW_REG, 8'h00, 8'hD8, 4'h9);
  endtask

  task t_by_imm;
    qb = '{8'hC1, 8'hDF, 8'hFF};
    run(1'b1);
    expect_dec(srd_pkg::OP_ROTATE_RIGHT_VIA_CARRY, 1'b1, 1'b0, srd_pkg::CNT_IMM, 8'hFF, 8'hDF, 4'h9);
    qb = '{8'hC0, 8'h7E, 8'h01};
    run(1'b0);
    expect_dec(srd_pkg::OP_ARITH_SHIFT_RIGHT, 1'b0, 1'b0, srd_pkg::CNT_IMM, 8'h01, 8'h7E, 4'h7);
  endtask

  task t_double;
    logic [7:0] sb [4];
    logic [7:0] mr;
    sb = '{8'hA4, 8'hA5, 8'hAC, 8'hAD};
    // every form once back to back and once with stalls between its bytes
    for (int i = 0; i < 8; i++) begin
      mr = i[0] ? 8'h4A : 8'hC8;
      qb = '{8'h0F, sb[i[1:0]], mr};
      if (!sb[i[1:0]][0]) qb.push_back(8'h1F);
      run(i[2]);
      expect_dec(sb[i[1:0]][3] ? 4'h9 : 4'h8, 1'b1, 1'b0, sb[i[1:0]][0] ? 2'h2 : 2'h3,
        sb[i[1:0]][0] ? 8'h00 : 8'h1F, mr, i[0] ? 4'h7 : 4'h3);
    end
  endtask

  task t_and;
    qb = '{8'h23, 8'hD9};
    run(1'b0);
    expect_dec(srd_pkg::OP_AND_REG, 1'b1, 1'b1, srd_pkg::CNT_NONE, 8'h00, 8'hD9, 4'h2);
    qb = '{8'h20, 8'hC1};
    run(1'b1);
    expect_dec(srd_pkg::OP_AND_REG, 1'b0, 1'b0, srd_pkg::CNT_NONE, 8'h00, 8'hC1, 4'h2);
  endtask

  // rejected sequences must leave the last decoded fields alone
  task t_undef;
    qb = '{8'hD1, 8'hF0};
    run(1'b0);
    chk({dec_vld, undef, op}, {2'h1, srd_pkg::OP_AND_REG});
    chk({a_vld, a_undef, a_op, a_cyc}, {2'h2, srd_pkg::OP_LOGICAL_SHIFT_LEFT, 4'h3});
    @(posedge ref_clk_i);
    #1;
    chk({undef, a_vld}, 2'h0);
    // a faulted selector leaves its immediate to be read as a new first byte
    qb = '{8'hC1, 8'hF0, 8'h07};
    run(1'b0);
    chk({dec_vld, undef, op}, {2'h1, srd_pkg::OP_AND_REG});
    chk({a_vld, a_undef, a_op, a_imm}, {2'h2, srd_pkg::OP_LOGICAL_SHIFT_LEFT, 8'h07});
    qb = '{8'h20, 8'h05};
    run(1'b1);
    chk({dec_vld, undef, op, cyc}, {2'h1, srd_pkg::OP_AND_REG, 4'h2});
    qb = '{8'h90};
    run(1'b0);
    chk({dec_vld, undef}, 2'h1);
    qb = '{8'h0F, 8'h00};
    run(1'b0);
    chk({dec_vld, undef, cyc}, 6'h12);
  endtask

  // a reset in mid-run clears every held field, then decoding resumes at once
  task t_reset;
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk({dec_vld, undef, op, size, dir, cnt, mem, cyc}, 15'h0);
    chk({imm, mod, rg, rm}, 16'h0);
    @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    qb = '{8'hD0, 8'hC0};
    run(1'b0);
    expect_dec(srd_pkg::OP_ROTATE_LEFT, 1'b0, 1'b0, srd_pkg::CNT_ONE, 8'h00, 8'hC0, 4'h3);
  endtask

  initial begin
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk({dec_vld, undef, op, cyc}, 10'h000);
    @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    t_by_one;
    t_by_count;
    t_by_imm;
    t_double;
    t_and;
    t_undef;
    t_reset;
    report_and_stop;
  end
endmodule // shift_rotate_and_decoder_bench
`default_nettype wire
